// File: rtl/bsr_beam_status.sv
// Beam status reporting: scan encoder, quality values and read-only object dictionary port.
`timescale 1ns/10ps
`include "bsr_map.svh"
module bsr_beam_status
  import bsr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_scan_valid,
  input wire logic [511:0] i_beam_blocked,
  input wire logic [9:0] i_beam_count,
  input wire logic i_numbering_reverse,
  input wire logic [11:0] i_rx_level,
  input wire logic [11:0] i_ref_level,
  input wire bsr_status_type i_status_flags,
  input wire logic i_teach_done,
  input wire logic i_teach_ok,
  input wire logic i_od_rd,
  input wire bsr_od_req_type i_od_req,
  output logic o_scan_ready,
  output logic [8:0] o_level_addr,
  output logic o_od_ack,
  output logic o_od_err,
  output logic [31:0] o_od_data
);

  // A count of zero or above the maximum would wreck the walk, so it is clamped into range.
  function automatic logic [9:0] clamp_count(input logic [9:0] cnt);
    if (cnt == 10'h000)
      clamp_count = 10'h001;
    else if (cnt > `BSR_BEAMS_MAX_CNT)
      clamp_count = `BSR_BEAMS_MAX_CNT;
    else
      clamp_count = cnt;
  endfunction

  function automatic logic [8:0] step_addr(input logic [8:0] addr, input logic rev);
    step_addr = rev ? addr - 9'h001 : addr + 9'h001;
  endfunction

  function automatic logic [`BSR_SUM_W-1:0] add_level(input logic [`BSR_SUM_W-1:0] sum, input logic [11:0] lvl);
    add_level = sum + {{(`BSR_SUM_W-`BSR_LEVEL_W){1'b0}}, lvl};
  endfunction

  bsr_state_type state_ff, nxt_state;
  logic [9:0] cnt_ff, nxt_cnt;
  logic [9:0] cnt_max_ff, nxt_cnt_max;
  logic [8:0] addr_ff, nxt_addr;
  logic rev_ff, nxt_rev;
  logic [511:0] blk_ff, nxt_blk;
  logic [511:0] bw_sh_ff, nxt_bw_sh;
  logic [15:0] rl_sh_ff [0:15];
  logic [15:0] nxt_rl_sh [0:15];
  logic [3:0] run_ff, nxt_run;
  logic cur_ff, nxt_cur;
  logic full_ff, nxt_full;
  logic [`BSR_SUM_W-1:0] rx_sum_ff, nxt_rx_sum;
  logic [`BSR_SUM_W-1:0] ref_sum_ff, nxt_ref_sum;
  logic [`BSR_REM_W-1:0] rem_ff, nxt_rem;
  logic [6:0] quo_ff, nxt_quo;
  logic [2:0] bit_ff, nxt_bit;
  logic [511:0] bw_ff, nxt_bw;
  logic [15:0] rl_ff [0:15];
  logic [15:0] nxt_rl [0:15];
  logic [6:0] pq_ff, nxt_pq;
  logic ready_ff, nxt_ready;
  bsr_status_type sys_ff, nxt_sys;
  logic beam_now;
  logic [`BSR_REM_W-1:0] div_den;

  assign beam_now = blk_ff[addr_ff];
  assign div_den = {{(`BSR_REM_W-`BSR_SUM_W){1'b0}}, ref_sum_ff} << bit_ff;

  // Scan engine: walks one beam per cycle into shadow copies, then publishes them at once.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_cnt_max = cnt_max_ff;
    nxt_addr = addr_ff;
    nxt_rev = rev_ff;
    nxt_blk = blk_ff;
    nxt_bw_sh = bw_sh_ff;
    nxt_rl_sh = rl_sh_ff;
    nxt_run = run_ff;
    nxt_cur = cur_ff;
    nxt_full = full_ff;
    nxt_rx_sum = rx_sum_ff;
    nxt_ref_sum = ref_sum_ff;
    nxt_rem = rem_ff;
    nxt_quo = quo_ff;
    nxt_bit = bit_ff;
    nxt_bw = bw_ff;
    nxt_rl = rl_ff;
    nxt_pq = pq_ff;
    nxt_sys = sys_ff;
    case (state_ff)
      BSR_IDLE:
      begin
        if (i_scan_valid)
        begin
          nxt_state = BSR_WALK;
          nxt_blk = i_beam_blocked;
          nxt_cnt_max = clamp_count(i_beam_count);
          nxt_rev = i_numbering_reverse;
          nxt_addr = i_numbering_reverse ? 9'(clamp_count(i_beam_count) - 10'h001) : 9'h000;
          nxt_cnt = 10'h000;
          nxt_bw_sh = '0;
          for (int i = 0; i < `BSR_RL_ENTRIES; i++)
            nxt_rl_sh[i] = 16'h0000;
          nxt_run = 4'h0;
          nxt_cur = 1'b0;
          nxt_full = 1'b0;
          nxt_rx_sum = '0;
          nxt_ref_sum = '0;
        end
      end
      BSR_WALK:
      begin
        nxt_bw_sh[cnt_ff[8:0]] = beam_now;
        if (beam_now == cur_ff)
          nxt_rl_sh[run_ff] = rl_sh_ff[run_ff] + 16'h0001;
        else if (run_ff != `BSR_RL_LAST)
        begin
          nxt_run = run_ff + 4'h1;
          nxt_rl_sh[run_ff + 4'h1] = 16'h0001;
          nxt_cur = beam_now;
        end
        else
          nxt_full = 1'b1;
        if (!beam_now)
        begin
          nxt_rx_sum = add_level(rx_sum_ff, i_rx_level);
          nxt_ref_sum = add_level(ref_sum_ff, i_ref_level);
        end
        nxt_addr = step_addr(addr_ff, rev_ff);
        nxt_cnt = cnt_ff + 10'h001;
        if (cnt_ff == cnt_max_ff - 10'h001)
        begin
          nxt_state = BSR_DIVIDE;
          nxt_addr = addr_ff;
          nxt_bit = `BSR_PCT_TOP;
          nxt_quo = 7'h00;
          nxt_rem = `BSR_REM_W'(nxt_rx_sum) * `BSR_PCT_SCALE;
        end
      end
      BSR_DIVIDE:
      begin
        // Fully blocked or brighter than taught both read as full quality; the quotient would overflow.
        if (ref_sum_ff == '0 || rx_sum_ff >= ref_sum_ff)
        begin
          nxt_quo = `BSR_PCT_FULL;
          nxt_state = BSR_COMMIT;
        end
        else
        begin
          if (rem_ff >= div_den)
          begin
            nxt_rem = rem_ff - div_den;
            nxt_quo[bit_ff] = 1'b1;
          end
          nxt_bit = bit_ff - 3'h1;
          if (bit_ff == 3'h0)
            nxt_state = BSR_COMMIT;
        end
      end
      BSR_COMMIT:
      begin
        nxt_bw = bw_sh_ff;
        nxt_rl = rl_sh_ff;
        nxt_pq = quo_ff;
        nxt_sys = i_status_flags;
        nxt_state = BSR_IDLE;
      end
      default:
        nxt_state = BSR_IDLE;
    endcase
    // Ready is registered so the pin comes straight from a flop, rising at the publish edge.
    nxt_ready = (nxt_state == BSR_IDLE);
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      state_ff <= BSR_IDLE;
      ready_ff <= 1'b1;
      cnt_ff <= 10'h000;
      cnt_max_ff <= 10'h001;
      addr_ff <= 9'h000;
      rev_ff <= 1'b0;
      blk_ff <= '0;
      bw_sh_ff <= '0;
      for (int i = 0; i < `BSR_RL_ENTRIES; i++)
      begin
        rl_sh_ff[i] <= 16'h0000;
        rl_ff[i] <= 16'h0000;
      end
      run_ff <= 4'h0;
      cur_ff <= 1'b0;
      full_ff <= 1'b0;
      rx_sum_ff <= '0;
      ref_sum_ff <= '0;
      rem_ff <= '0;
      quo_ff <= 7'h00;
      bit_ff <= 3'h0;
      bw_ff <= '0;
      pq_ff <= `BSR_PQ_RESET;
      sys_ff <= `BSR_SYS_RESET;
    end
    else
    begin
      state_ff <= nxt_state;
      ready_ff <= nxt_ready;
      cnt_ff <= nxt_cnt;
      cnt_max_ff <= nxt_cnt_max;
      addr_ff <= nxt_addr;
      rev_ff <= nxt_rev;
      blk_ff <= nxt_blk;
      bw_sh_ff <= nxt_bw_sh;
      rl_sh_ff <= nxt_rl_sh;
      rl_ff <= nxt_rl;
      run_ff <= nxt_run;
      cur_ff <= nxt_cur;
      full_ff <= nxt_full;
      rx_sum_ff <= nxt_rx_sum;
      ref_sum_ff <= nxt_ref_sum;
      rem_ff <= nxt_rem;
      quo_ff <= nxt_quo;
      bit_ff <= nxt_bit;
      bw_ff <= nxt_bw;
      pq_ff <= nxt_pq;
      sys_ff <= nxt_sys;
    end
  end

  // Teach quality moves only on a completed teach-in.
  logic [15:0] tq_ff, nxt_tq;

  always_comb
  begin
    nxt_tq = tq_ff;
    if (i_teach_done)
      nxt_tq = i_teach_ok ? `BSR_QUAL_FULL : `BSR_QUAL_ZERO;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      tq_ff <= `BSR_TQ_RESET;
    else
      tq_ff <= nxt_tq;
  end

  // Object dictionary read port: answers one cycle after the strobe.
  logic ack_ff, nxt_ack;
  logic err_ff, nxt_err;
  logic [31:0] data_ff, nxt_data;
  logic sub_in_array;
  logic [3:0] sub_sel;

  assign sub_in_array = i_od_req.subindex >= `BSR_SUB_FIRST && i_od_req.subindex <= `BSR_SUB_LAST;
  assign sub_sel = 4'(i_od_req.subindex - `BSR_SUB_FIRST);

  always_comb
  begin
    nxt_ack = i_od_rd;
    nxt_err = 1'b0;
    nxt_data = 32'h0000_0000;
    if (i_od_rd)
    begin
      case (i_od_req.index)
        `BSR_OBJ_SYS:
          if (i_od_req.subindex == `BSR_SUB_ZERO)
            nxt_data = {24'h00_0000, sys_ff};
          else
            nxt_err = 1'b1;
        `BSR_OBJ_PQ:
          if (i_od_req.subindex == `BSR_SUB_ZERO)
            nxt_data = {25'h000_0000, pq_ff};
          else
            nxt_err = 1'b1;
        `BSR_OBJ_TQ:
          if (i_od_req.subindex == `BSR_SUB_ZERO)
            nxt_data = {16'h0000, tq_ff};
          else
            nxt_err = 1'b1;
        `BSR_OBJ_RL:
          if (i_od_req.subindex == `BSR_SUB_ZERO)
            nxt_data = `BSR_ARRAY_LEN;
          else if (sub_in_array)
            nxt_data = {16'h0000, rl_ff[sub_sel]};
          else
            nxt_err = 1'b1;
        `BSR_OBJ_BW:
          if (i_od_req.subindex == `BSR_SUB_ZERO)
            nxt_data = `BSR_ARRAY_LEN;
          else if (sub_in_array)
            nxt_data = bw_ff[sub_sel * `BSR_WORD_BITS +: `BSR_WORD_BITS];
          else
            nxt_err = 1'b1;
        default:
          nxt_err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
      data_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= nxt_ack;
      err_ff <= nxt_err;
      data_ff <= nxt_data;
    end
  end

  assign o_scan_ready = ready_ff;
  assign o_level_addr = addr_ff;
  assign o_od_ack = ack_ff;
  assign o_od_err = err_ff;
  assign o_od_data = data_ff;

  a_sys_upper_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_od_rd && i_od_req.index == `BSR_OBJ_SYS |=> o_od_data[31:8] == 24'h00_0000)
    else $error("System status upper bits not zero.");

  a_sys_flag_capture: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    state_ff == BSR_COMMIT |=> sys_ff == $past(i_status_flags))
    else $error("Status flags not captured at publish.");

  a_pq_in_range: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    pq_ff <= `BSR_PCT_FULL)
    else $error("Process quality above full scale.");

  a_pq_full_light: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    state_ff == BSR_DIVIDE && rx_sum_ff >= ref_sum_ff |=> ##1 pq_ff == `BSR_PCT_FULL)
    else $error("Full light did not give full quality.");

  a_tq_update: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_teach_done |=> tq_ff == ($past(i_teach_ok) ? `BSR_QUAL_FULL : `BSR_QUAL_ZERO))
    else $error("Teach quality wrong after teach-in.");

  a_tq_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !i_teach_done |=> $stable(tq_ff))
    else $error("Teach quality changed without teach-in.");

  a_rl_sub_range: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_od_rd && i_od_req.index == `BSR_OBJ_RL && i_od_req.subindex > `BSR_SUB_LAST |=> o_od_ack && o_od_err)
    else $error("Run-length sub-index past the last entry not refused.");

  a_rl_alternate: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    state_ff == BSR_WALK && beam_now != cur_ff && run_ff != `BSR_RL_LAST
    |=> run_ff == $past(run_ff) + 4'h1 && cur_ff != $past(cur_ff))
    else $error("Run index did not advance on a state change.");

  a_rl_first_made: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    state_ff == BSR_COMMIT && bw_sh_ff[0] |=> rl_ff[0] == 16'h0000)
    else $error("First run entry not zero with first beam blocked.");

  a_beam_bit: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    state_ff == BSR_WALK |=> bw_sh_ff[$past(cnt_ff[8:0])] == $past(beam_now))
    else $error("Beam bit does not match beam state.");

  a_beam_order: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    state_ff == BSR_WALK && cnt_ff != cnt_max_ff - 10'h001
    |=> addr_ff == ($past(rev_ff) ? $past(addr_ff) - 9'h001 : $past(addr_ff) + 9'h001))
    else $error("Beam walk order wrong.");

  a_bw_word_one: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_od_rd && i_od_req.index == `BSR_OBJ_BW && i_od_req.subindex == `BSR_SUB_FIRST
    && state_ff != BSR_COMMIT |=> o_od_data == bw_ff[31:0])
    else $error("First beam word wrong.");

  a_bw_spare_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    state_ff == BSR_COMMIT |-> (bw_sh_ff >> cnt_max_ff) == '0)
    else $error("Bits beyond the last beam not zero.");

  a_snapshot_only: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    state_ff != BSR_COMMIT |=> $stable(bw_ff) && $stable(pq_ff) && $stable(sys_ff))
    else $error("Published values changed outside publish.");

endmodule

// File: rtl/bsr_map.svh
// Offsets, field positions, reset values and counts of the beam status reporting block.
`ifndef BSR_MAP_SVH
`define BSR_MAP_SVH

`define BSR_OBJ_SYS 16'h2211
`define BSR_OBJ_PQ 16'h2212
`define BSR_OBJ_TQ 16'h2213
`define BSR_OBJ_RL 16'h2220
`define BSR_OBJ_BW 16'h2230

`define BSR_SUB_ZERO 8'h00
`define BSR_SUB_FIRST 8'h01
`define BSR_SUB_LAST 8'h10
`define BSR_ARRAY_LEN 32'h0000_0010

`define BSR_RL_ENTRIES 16
`define BSR_RL_LAST 4'hF
`define BSR_BEAMS_MAX 512
`define BSR_BEAMS_MAX_CNT 10'h200
`define BSR_WORD_BITS 32
`define BSR_LEVEL_W 12
`define BSR_SUM_W 21
`define BSR_REM_W 28
`define BSR_PCT_TOP 3'h6

`define BSR_QUAL_ZERO 16'h0000
`define BSR_QUAL_FULL 16'h0064
`define BSR_PCT_FULL 7'h64
`define BSR_PCT_SCALE 28'h000_0064

`define BSR_SYS_RESET 8'h00
`define BSR_PQ_RESET 7'h00
`define BSR_TQ_RESET 16'h0000

`endif

// File: rtl/bsr_pkg.sv
// Types shared by the beam status reporting block.
package bsr_pkg;

  typedef enum logic [1:0] {
    BSR_IDLE,
    BSR_WALK,
    BSR_DIVIDE,
    BSR_COMMIT
  } bsr_state_type;

  typedef struct packed {
    logic sync_error;
    logic teach_error;
    logic hardware_error;
    logic contamination;
    logic teach_active;
    logic overtemperature;
    logic process_data_invalid;
    logic output_short_circuit;
  } bsr_status_type;

  typedef struct packed {
    logic [15:0] index;
    logic [7:0] subindex;
  } bsr_od_req_type;

endpackage

// File: sim/bsr_level_source.sv
// Received and taught light levels seen by the block for each physical beam.
`timescale 1ns/10ps
module bsr_level_source
(
  input wire logic [8:0] i_addr,
  input wire logic i_half,
  output logic [11:0] o_rx,
  output logic [11:0] o_ref
);
  // References are kept even, so halving the received light gives exactly half the total.
  assign o_ref = 12'h0C8 + {2'h0, i_addr, 1'b0};
  assign o_rx = i_half ? {1'b0, o_ref[11:1]} : o_ref;
endmodule

// File: sim/tb_beam_status_reporting.sv
// Self-checking bench for the beam status reporting block.
`timescale 1ns/10ps
module tb_beam_status_reporting
  import bsr_pkg::*;
;
  logic i_clk_sys, i_rst, i_scan_valid, i_numbering_reverse, i_teach_done, i_teach_ok, i_od_rd, half;
  logic [511:0] i_beam_blocked;
  logic [9:0] i_beam_count;
  logic [11:0] i_rx_level, i_ref_level;
  bsr_status_type i_status_flags;
  bsr_od_req_type i_od_req;
  logic o_scan_ready, o_od_ack, o_od_err;
  logic [8:0] o_level_addr;
  logic [31:0] o_od_data;
  logic [511:0] lg;
  logic [15:0] rl [16];
  int fail_count, samples_checked;

  bsr_beam_status i_bsr_beam_status (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_scan_valid(i_scan_valid),
    .i_beam_blocked(i_beam_blocked), .i_beam_count(i_beam_count), .i_numbering_reverse(i_numbering_reverse),
    .i_rx_level(i_rx_level), .i_ref_level(i_ref_level), .i_status_flags(i_status_flags),
    .i_teach_done(i_teach_done), .i_teach_ok(i_teach_ok), .i_od_rd(i_od_rd), .i_od_req(i_od_req),
    .o_scan_ready(o_scan_ready), .o_level_addr(o_level_addr), .o_od_ack(o_od_ack), .o_od_err(o_od_err),
    .o_od_data(o_od_data));

  bsr_level_source i_bsr_level_source (.i_addr(o_level_addr), .i_half(half), .o_rx(i_rx_level),
    .o_ref(i_ref_level));

  initial
  begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end

  task automatic close_out();
    $display("Comparisons: %0d, mismatches: %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [33:0] got, input logic [33:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One read: the answer stands for the single cycle after the taking edge.
  task automatic od_read(input logic [15:0] idx, input logic [7:0] sub, input logic err, input logic [31:0] exp);
    @(posedge i_clk_sys);
    i_od_rd <= 1'b1;
    i_od_req <= '{index: idx, subindex: sub};
    @(posedge i_clk_sys);
    i_od_rd <= 1'b0;
    #1;
    check({o_od_ack, o_od_err, o_od_data}, {1'b1, err, exp}, "object read");
  endtask

  // Reference encoding: logical beam order, then alternating made and blocked run counts.
  task automatic model(input logic [511:0] p, input int c, input bit rev);
    int e;
    logic cur;
    lg = '0;
    for (int k = 0; k < c; k++)
    begin
      lg[k] = rev ? p[c - 1 - k] : p[k];
    end
    for (int k = 0; k < 16; k++)
    begin
      rl[k] = 16'h0000;
    end
    e = 0;
    cur = 1'b0;
    for (int k = 0; k < c; k++)
    begin
      if (lg[k] !== cur)
      begin
        cur = ~cur;
        e++;
      end
      rl[e] = rl[e] + 16'h0001;
    end
  endtask

  task automatic check_all(input logic [7:0] flags, input logic [31:0] pq);
    od_read(16'h2211, 8'h00, 1'b0, {24'h00_0000, flags});
    od_read(16'h2212, 8'h00, 1'b0, pq);
    for (int i = 0; i < 16; i++)
    begin
      od_read(16'h2220, 8'(i + 1), 1'b0, {16'h0000, rl[i]});
      od_read(16'h2230, 8'(i + 1), 1'b0, lg[32 * i +: 32]);
    end
  endtask

  // Offers one scan and checks when the new snapshot is published.
  task automatic scan(input logic [511:0] p, input logic [9:0] cnt, input bit rev, input bit h);
    int c;
    int n;
    int exp_n;
    c = (cnt > 10'h200) ? 512 : int'(cnt);
    model(p, c, rev);
    // Walk of c beams, divide of 1 or 7 cycles, then the publish cycle, counted from the taking edge.
    exp_n = c + 1 + ((h && (c - $countones(lg)) > 0) ? 7 : 1);
    @(posedge i_clk_sys);
    i_scan_valid <= 1'b1;
    i_beam_blocked <= p;
    i_beam_count <= cnt;
    i_numbering_reverse <= rev;
    half <= h;
    @(posedge i_clk_sys);
    i_scan_valid <= 1'b0;
    for (n = 1; n <= 1100; n++)
    begin
      @(posedge i_clk_sys);
      #1;
      if (o_scan_ready === 1'b1)
      begin
        break;
      end
    end
    if (n > 1100)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t scan never finished", $time);
      close_out();
    end
    else
    begin
      check(34'(n), 34'(exp_n), "publish latency");
    end
  endtask

  task automatic teach(input logic ok);
    @(posedge i_clk_sys);
    i_teach_done <= 1'b1;
    i_teach_ok <= ok;
    @(posedge i_clk_sys);
    i_teach_done <= 1'b0;
    od_read(16'h2213, 8'h00, 1'b0, ok ? 32'h0000_0064 : 32'h0000_0000);
  endtask

  initial
  begin
    i_rst = 1'b1;
    i_scan_valid = 1'b0;
    i_beam_blocked = '0;
    i_beam_count = 10'h000;
    i_numbering_reverse = 1'b0;
    i_teach_done = 1'b0;
    i_teach_ok = 1'b0;
    i_od_rd = 1'b0;
    i_od_req = '0;
    half = 1'b0;
    i_status_flags = bsr_status_type'(8'hA5);
    fail_count = 0;
    samples_checked = 0;
    repeat (6) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    model('0, 0, 1'b0);
    check_all(8'h00, 32'h0000_0000);
    od_read(16'h2214, 8'h00, 1'b1, 32'h0000_0000);
    od_read(16'h2211, 8'h01, 1'b1, 32'h0000_0000);
    od_read(16'h2220, 8'h11, 1'b1, 32'h0000_0000);
    od_read(16'h2230, 8'h00, 1'b0, 32'h0000_0010);
    teach(1'b1);
    // Bits 30 and 31 are set but lie beyond the 30 physical beams.
    scan({480'h0, 32'hC1E0_781E}, 10'h01E, 1'b0, 1'b0);
    i_status_flags <= bsr_status_type'(8'h5A);
    check_all(8'hA5, 32'h0000_0064);
    scan({480'h0, 32'h01E0_781F}, 10'h01E, 1'b0, 1'b1);
    check_all(8'h5A, 32'h0000_0032);
    scan({480'h0, 32'hC1E0_781E}, 10'h01E, 1'b1, 1'b0);
    check_all(8'h5A, 32'h0000_0064);
    od_read(16'h2213, 8'h00, 1'b0, 32'h0000_0064);
    teach(1'b0);
    scan({512{1'b1}}, 10'h3FF, 1'b0, 1'b1);
    check_all(8'h5A, 32'h0000_0064);
    close_out();
  end
endmodule
